// >>> bdpe_pkg.sv
// shared constants and carrier types for the bulk-only data-phase error handler
package bdpe_pkg;
    localparam int unsigned BDPE_LEN_W = 32;
    localparam int unsigned BDPE_BYTE_W = 8;
    localparam int unsigned BDPE_FIFO_DEPTH = 16;
    localparam logic [7:0] BDPE_ST_PASS = 8'h00;
    localparam logic [7:0] BDPE_ST_FAIL = 8'h01;
    localparam logic [7:0] BDPE_ST_PHASE = 8'h02;
    localparam logic [7:0] BDPE_FILL_BYTE = 8'h00;
    localparam logic [31:0] BDPE_LEN_ZERO = 32'h0000_0000;
    localparam logic [31:0] BDPE_LEN_ONE = 32'h0000_0001;

    typedef enum logic [1:0] {
        BDPE_CMD_NONE,
        BDPE_CMD_READ,
        BDPE_CMD_WRITE,
        BDPE_CMD_UNSUP
    } bdpe_cmd_type;

    typedef enum logic [1:0] {
        BDPE_MODE_NODATA,
        BDPE_MODE_IN,
        BDPE_MODE_OUT
    } bdpe_mode_type;

    typedef enum logic [1:0] {
        BDPE_PH_IDLE,
        BDPE_PH_IN,
        BDPE_PH_OUT,
        BDPE_PH_STATUS
    } bdpe_phase_type;

    // what the command wrapper and command decoder announce
    typedef struct packed {
        bdpe_cmd_type kind;
        logic host_in;
        logic [31:0] host_len;
        logic [31:0] dev_len;
    } bdpe_cbw_type;

    // outcome of comparing the two announced lengths
    typedef struct packed {
        bdpe_mode_type mode;
        logic [7:0] status;
        logic [31:0] fetch_len;
        logic dir_err;
        logic len_err;
    } bdpe_class_type;

    typedef struct packed {
        logic [7:0] status;
        logic [31:0] residue;
    } bdpe_csw_type;
endpackage

// >>> bdpe_fifo.sv
// byte fifo between the data source and the bulk-in stage
module bdpe_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // fill side
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    // drain side
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wr;
        logic [AW:0] rd;
    } bdpe_fifo_st_type;

    bdpe_fifo_st_type st_q;
    bdpe_fifo_st_type st_d;
    logic full;
    logic empty;

    // extra pointer bit tells full from empty when the indices meet
    assign empty = (st_q.wr == st_q.rd);
    assign full = (st_q.wr[AW-1:0] == st_q.rd[AW-1:0]) && (st_q.wr[AW] != st_q.rd[AW]);
    assign in_ready_out = !full;
    assign out_valid_out = !empty;
    assign out_data_out = st_q.mem[st_q.rd[AW-1:0]];

    always_comb
    begin
        st_d = st_q;
        if (in_valid_in && !full)
        begin
            st_d.mem[st_q.wr[AW-1:0]] = in_data_in;
            st_d.wr = st_q.wr + 1'b1;
        end
        if (out_ready_in && !empty)
        begin
            st_d.rd = st_q.rd + 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end
endmodule

// >>> bdpe_classify.sv
// sorts a command into data direction, byte budget and final status
module bdpe_classify (
    // announced transfer
    input bdpe_pkg::bdpe_cbw_type cbw_in,
    // verdict
    output bdpe_pkg::bdpe_class_type cls_out
);
    import bdpe_pkg::*;

    logic [31:0] dev_eff;

    always_comb
    begin
        // a command with no data stage never plans any bytes
        dev_eff = (cbw_in.kind == BDPE_CMD_NONE) ? BDPE_LEN_ZERO : cbw_in.dev_len;
        cls_out.mode = BDPE_MODE_NODATA;
        cls_out.status = BDPE_ST_PASS;
        cls_out.fetch_len = BDPE_LEN_ZERO;
        cls_out.dir_err = 1'b0;
        cls_out.len_err = 1'b0;
        if (cbw_in.host_len == BDPE_LEN_ZERO)
        begin
            if (cbw_in.kind == BDPE_CMD_UNSUP)
            begin
                cls_out.status = BDPE_ST_FAIL;
            end
            else if (dev_eff != BDPE_LEN_ZERO)
            begin
                cls_out.status = BDPE_ST_PHASE;
                cls_out.len_err = 1'b1;
            end
        end
        else if (cbw_in.host_in)
        begin
            cls_out.mode = BDPE_MODE_IN;
            case (cbw_in.kind)
                BDPE_CMD_WRITE:
                begin
                    cls_out.status = BDPE_ST_PHASE;
                    cls_out.dir_err = 1'b1;
                end
                BDPE_CMD_UNSUP:
                begin
                    cls_out.status = BDPE_ST_FAIL;
                end
                default:
                begin
                    if (dev_eff > cbw_in.host_len)
                    begin
                        cls_out.fetch_len = cbw_in.host_len;
                        cls_out.status = BDPE_ST_PHASE;
                        cls_out.len_err = 1'b1;
                    end
                    else
                    begin
                        cls_out.fetch_len = dev_eff;
                        cls_out.status = BDPE_ST_PASS;
                        cls_out.len_err = (dev_eff != cbw_in.host_len);
                    end
                end
            endcase
        end
        else
        begin
            cls_out.mode = BDPE_MODE_OUT;
            case (cbw_in.kind)
                BDPE_CMD_READ:
                begin
                    cls_out.status = BDPE_ST_PHASE;
                    cls_out.dir_err = 1'b1;
                end
                BDPE_CMD_UNSUP:
                begin
                    cls_out.status = BDPE_ST_FAIL;
                end
                default:
                begin
                    if (dev_eff > cbw_in.host_len)
                    begin
                        cls_out.fetch_len = cbw_in.host_len;
                        cls_out.status = BDPE_ST_PHASE;
                        cls_out.len_err = 1'b1;
                    end
                    else
                    begin
                        cls_out.fetch_len = dev_eff;
                        cls_out.len_err = (dev_eff != cbw_in.host_len);
                        cls_out.status = cls_out.len_err ? BDPE_ST_FAIL : BDPE_ST_PASS;
                    end
                end
            endcase
        end
    end
endmodule

// >>> bdpe_top.sv
// data-phase sequencer: counters, padding, absorbing and status wrapper build
module bdpe_top (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    // command wrapper
    input wire logic cbw_valid_in,
    input bdpe_pkg::bdpe_cbw_type cbw_in,
    output logic cbw_ready_out,
    // device data source for bulk-in
    input wire logic src_valid_in,
    input wire logic [7:0] src_data_in,
    output logic src_ready_out,
    // bulk-in toward host
    output logic in_valid_out,
    output logic [7:0] in_data_out,
    input wire logic in_ready_in,
    // bulk-out from host
    input wire logic out_valid_in,
    input wire logic [7:0] out_data_in,
    output logic out_ready_out,
    // device data sink for bulk-out
    output logic snk_valid_out,
    output logic [7:0] snk_data_out,
    input wire logic snk_ready_in,
    // status wrapper
    output logic csw_valid_out,
    output bdpe_pkg::bdpe_csw_type csw_out,
    input wire logic csw_ready_in,
    // transaction state
    output logic busy_out,
    output logic dir_err_out,
    output logic len_err_out
);
    import bdpe_pkg::*;

    typedef struct packed {
        bdpe_phase_type phase;
        bdpe_class_type cls;
        logic [31:0] host_len;
        logic [31:0] host_left;
        logic [31:0] dev_left;
        logic [31:0] fetch_left;
        logic fetch_en;
        logic in_valid;
        logic [7:0] in_data;
        logic in_fill;
        logic out_ready;
        logic snk_valid;
        logic [7:0] snk_data;
        logic csw_valid;
        bdpe_csw_type csw;
        logic cbw_ready;
        logic busy;
        logic dir_err;
        logic len_err;
        logic [31:0] handled;
    } bdpe_top_st_type;

    bdpe_top_st_type st_q;
    bdpe_top_st_type st_d;
    bdpe_class_type cls;
    logic rst_meta_q;
    logic rst_n;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic fifo_pop;
    logic src_push;
    logic in_free;
    logic out_take;

    // reset is asserted asynchronously at once but is released through two flops
    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    bdpe_classify u_classify (
        .cbw_in(cbw_in),
        .cls_out(cls)
    );

    // source is asked only for the bytes that will really be sent, so a
    // truncated read never leaves stale bytes behind in the fifo
    assign src_push = src_valid_in && st_q.fetch_en && fifo_in_ready;
    assign src_ready_out = st_q.fetch_en && fifo_in_ready;

    bdpe_fifo #(
        .WIDTH(BDPE_BYTE_W),
        .DEPTH(BDPE_FIFO_DEPTH)
    ) u_fifo (
        .clk_in(sys_clk_in),
        .rst_n_in(rst_n),
        .in_valid_in(src_valid_in && st_q.fetch_en),
        .in_data_in(src_data_in),
        .in_ready_out(fifo_in_ready),
        .out_valid_out(fifo_out_valid),
        .out_data_out(fifo_out_data),
        .out_ready_in(fifo_pop)
    );

    assign in_free = !st_q.in_valid || in_ready_in;
    assign out_take = out_valid_in && st_q.out_ready;
    assign fifo_pop = (st_q.phase == BDPE_PH_IN) && in_free && (st_q.host_left != BDPE_LEN_ZERO)
        && (st_q.dev_left != BDPE_LEN_ZERO) && fifo_out_valid;

    always_comb
    begin
        st_d = st_q;
        if (snk_ready_in)
        begin
            st_d.snk_valid = 1'b0;
        end
        if (in_ready_in)
        begin
            st_d.in_valid = 1'b0;
        end
        if (src_push)
        begin
            st_d.fetch_left = st_q.fetch_left - BDPE_LEN_ONE;
        end
        case (st_q.phase)
            BDPE_PH_IDLE:
            begin
                if (cbw_valid_in && st_q.cbw_ready)
                begin
                    st_d.cls = cls;
                    st_d.host_len = cbw_in.host_len;
                    st_d.host_left = cbw_in.host_len;
                    st_d.handled = BDPE_LEN_ZERO;
                    st_d.dev_left = cls.fetch_len;
                    st_d.fetch_left = (cls.mode == BDPE_MODE_IN) ? cls.fetch_len : BDPE_LEN_ZERO;
                    case (cls.mode)
                        BDPE_MODE_IN: st_d.phase = BDPE_PH_IN;
                        BDPE_MODE_OUT: st_d.phase = BDPE_PH_OUT;
                        default: st_d.phase = BDPE_PH_STATUS;
                    endcase
                end
            end
            BDPE_PH_IN:
            begin
                if (in_free && (st_q.host_left != BDPE_LEN_ZERO))
                begin
                    if (st_q.dev_left != BDPE_LEN_ZERO)
                    begin
                        if (fifo_out_valid)
                        begin
                            st_d.in_valid = 1'b1;
                            st_d.in_data = fifo_out_data;
                            st_d.in_fill = 1'b0;
                            st_d.dev_left = st_q.dev_left - BDPE_LEN_ONE;
                            st_d.handled = st_q.handled + BDPE_LEN_ONE;
                            st_d.host_left = st_q.host_left - BDPE_LEN_ONE;
                        end
                    end
                    else
                    begin
                        // nothing left to send: zero filler up to host length
                        st_d.in_valid = 1'b1;
                        st_d.in_data = BDPE_FILL_BYTE;
                        st_d.in_fill = 1'b1;
                        st_d.host_left = st_q.host_left - BDPE_LEN_ONE;
                    end
                end
                else if (in_free)
                begin
                    st_d.phase = BDPE_PH_STATUS;
                end
            end
            BDPE_PH_OUT:
            begin
                if (out_take)
                begin
                    st_d.host_left = st_q.host_left - BDPE_LEN_ONE;
                    if (st_q.dev_left != BDPE_LEN_ZERO)
                    begin
                        st_d.dev_left = st_q.dev_left - BDPE_LEN_ONE;
                        st_d.handled = st_q.handled + BDPE_LEN_ONE;
                        st_d.snk_valid = 1'b1;
                        st_d.snk_data = out_data_in;
                    end
                end
                else if ((st_q.host_left == BDPE_LEN_ZERO) && !st_q.snk_valid)
                begin
                    st_d.phase = BDPE_PH_STATUS;
                end
            end
            BDPE_PH_STATUS:
            begin
                if (csw_ready_in && st_q.csw_valid)
                begin
                    st_d.csw_valid = 1'b0;
                    st_d.phase = BDPE_PH_IDLE;
                end
            end
            default:
            begin
                st_d.phase = BDPE_PH_IDLE;
            end
        endcase
        // status built on entry: host length minus bytes the function handled
        if ((st_d.phase == BDPE_PH_STATUS) && (st_q.phase != BDPE_PH_STATUS))
        begin
            st_d.csw_valid = 1'b1;
            st_d.csw.status = st_d.cls.status;
            st_d.csw.residue = st_d.host_len
                - (st_d.cls.fetch_len - st_d.dev_left);
        end
        st_d.fetch_en = (st_d.phase == BDPE_PH_IN) && (st_d.fetch_left != BDPE_LEN_ZERO);
        // one byte in flight toward the sink at a time keeps ready registered
        st_d.out_ready = (st_d.phase == BDPE_PH_OUT) && (st_d.host_left != BDPE_LEN_ZERO)
            && !st_d.snk_valid;
        st_d.cbw_ready = (st_d.phase == BDPE_PH_IDLE);
        // flags are registered so the pins never glitch while the phase changes
        st_d.busy = (st_d.phase != BDPE_PH_IDLE);
        st_d.dir_err = st_d.cls.dir_err && st_d.busy;
        st_d.len_err = st_d.cls.len_err && st_d.busy;
    end

    always_ff @(posedge sys_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign cbw_ready_out = st_q.cbw_ready;
    assign in_valid_out = st_q.in_valid;
    assign in_data_out = st_q.in_data;
    assign out_ready_out = st_q.out_ready;
    assign snk_valid_out = st_q.snk_valid;
    assign snk_data_out = st_q.snk_data;
    assign csw_valid_out = st_q.csw_valid;
    assign csw_out = st_q.csw;
    assign busy_out = st_q.busy;
    assign dir_err_out = st_q.dir_err;
    assign len_err_out = st_q.len_err;

    cbw_opens_txn_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        cbw_valid_in && cbw_ready_out |=> busy_out && !cbw_ready_out)
        else $error("command wrapper did not open a transaction");

    csw_closes_txn_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        csw_valid_out && csw_ready_in |=> !csw_valid_out ##0 cbw_ready_out)
        else $error("status handshake did not close the transaction");

    csw_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        csw_valid_out && !csw_ready_in |=> csw_valid_out && $stable(csw_out))
        else $error("status wrapper changed before it was taken");

    out_count_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        out_valid_in && out_ready_out |=> st_q.host_left == $past(st_q.host_left) - BDPE_LEN_ONE)
        else $error("host counter did not drop by one per out byte");

    host_len_done_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        $rose(csw_valid_out) |-> st_q.host_left == BDPE_LEN_ZERO)
        else $error("status sent before host length was covered");

    residue_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        $rose(csw_valid_out)
        |-> csw_out.residue == st_q.host_len - st_q.handled)
        else $error("residue is not host length minus bytes handled");

    fill_zero_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        in_valid_out && st_q.in_fill |-> in_data_out == BDPE_FILL_BYTE)
        else $error("filler byte is not zero");

    zero_len_phase_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        $rose(csw_valid_out) && st_q.cls.len_err && st_q.cls.mode == BDPE_MODE_NODATA
        |-> csw_out.status == BDPE_ST_PHASE && csw_out.residue == BDPE_LEN_ZERO)
        else $error("zero host length with planned data is not a phase error");

    dir_err_status_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        $rose(csw_valid_out) && st_q.cls.dir_err
        |-> csw_out.status == BDPE_ST_PHASE && csw_out.residue == st_q.host_len)
        else $error("direction mismatch not reported as phase error");

    no_in_on_out_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        st_q.phase == BDPE_PH_OUT |-> !in_valid_out && !src_ready_out)
        else $error("bulk-in activity during an out data stage");

    out_absorb_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        out_valid_in && out_ready_out && st_q.dev_left == BDPE_LEN_ZERO |=> !snk_valid_out)
        else $error("absorbed out byte reached the sink");
endmodule

// >>> bdpe_host_model.sv
// behavioural host: takes bulk-in bytes, sends bulk-out bytes, reads the status wrapper
module bdpe_host_model (
    // clock and control
    input wire logic clk_in,
    input wire logic clr_in,
    input wire logic slow_in,
    input wire logic hold_in,
    input wire logic [31:0] send_n_in,
    // bulk-in
    input wire logic in_valid_in,
    input wire logic [7:0] in_data_in,
    output logic in_ready_out,
    // bulk-out
    output logic out_valid_out,
    output logic [7:0] out_data_out,
    input wire logic out_ready_in,
    // status wrapper
    input wire logic csw_valid_in,
    input bdpe_pkg::bdpe_csw_type csw_in,
    output logic csw_ready_out,
    // observations
    output logic [31:0] in_cnt_out,
    output logic [31:0] in_nz_out,
    output logic got_out,
    output bdpe_pkg::bdpe_csw_type csw_got_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import bdpe_pkg::*;
    logic [31:0] sent_q;

    initial
    begin
        {in_ready_out, out_valid_out, csw_ready_out, out_data_out} = '0;
    end

    always @(posedge clk_in)
    begin
        in_ready_out <= !hold_in && (!slow_in || !in_ready_out);
        // status is always collected before a new wrapper goes out
        csw_ready_out <= csw_valid_in && !csw_ready_out;
        if (clr_in)
            {sent_q, in_cnt_out, in_nz_out, got_out, out_valid_out} <= '0;
        else
        begin
            if (in_valid_in && in_ready_out)
            begin
                in_cnt_out <= in_cnt_out + 32'h1;
                in_nz_out <= in_nz_out + {31'h0, in_data_in != 8'h00};
            end
            if (csw_valid_in && csw_ready_out)
            begin
                got_out <= 1'b1;
                csw_got_out <= csw_in;
            end
            if (out_valid_out && out_ready_in)
            begin
                sent_q <= sent_q + 32'h1;
                out_valid_out <= 1'b0;
                // a released line must not keep showing the last byte
                out_data_out <= ~out_data_out;
            end
            else if (!out_valid_out && sent_q < send_n_in && !(slow_in && in_ready_out))
            begin
                out_valid_out <= 1'b1;
                out_data_out <= 8'hC3;
            end
        end
    end
endmodule

// >>> tb_top.sv
// self-checking bench for the bulk-only data-phase error handler
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import bdpe_pkg::*;
    localparam logic [31:0] SKIP = 32'hFFFF_FFFF;
    logic clk, arst_n, cbw_valid, cbw_ready, src_valid, src_ready, in_valid, in_ready;
    logic out_valid, out_ready, snk_valid, snk_ready, csw_valid, csw_ready, busy;
    logic clr, slow, hold, got, dir_err, len_err;
    logic [7:0] src_data, in_data, out_data, snk_data;
    logic [31:0] send_n, in_cnt, in_nz, src_cnt, snk_cnt;
    bdpe_cbw_type cbw;
    bdpe_csw_type csw, csw_got;
    int errors, tests_run;

    bdpe_top bdpe_top_inst (.sys_clk_in(clk), .arst_n_in(arst_n), .cbw_valid_in(cbw_valid),
        .cbw_in(cbw), .cbw_ready_out(cbw_ready), .src_valid_in(src_valid),
        .src_data_in(src_data), .src_ready_out(src_ready), .in_valid_out(in_valid),
        .in_data_out(in_data), .in_ready_in(in_ready), .out_valid_in(out_valid),
        .out_data_in(out_data), .out_ready_out(out_ready), .snk_valid_out(snk_valid),
        .snk_data_out(snk_data), .snk_ready_in(snk_ready), .csw_valid_out(csw_valid),
        .csw_out(csw), .csw_ready_in(csw_ready), .busy_out(busy), .dir_err_out(dir_err),
        .len_err_out(len_err));

    bdpe_host_model bdpe_host_model_inst (.clk_in(clk), .clr_in(clr), .slow_in(slow),
        .hold_in(hold), .send_n_in(send_n), .in_valid_in(in_valid), .in_data_in(in_data),
        .in_ready_out(in_ready), .out_valid_out(out_valid), .out_data_out(out_data),
        .out_ready_in(out_ready), .csw_valid_in(csw_valid), .csw_in(csw),
        .csw_ready_out(csw_ready), .in_cnt_out(in_cnt), .in_nz_out(in_nz), .got_out(got),
        .csw_got_out(csw_got));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // device source and a sink that stalls every other cycle
    always @(posedge clk)
    begin
        snk_ready <= ~snk_ready;
        if (clr)
            {src_cnt, snk_cnt} <= '0;
        else
        begin
            if (src_valid && src_ready)
                src_cnt <= src_cnt + 32'h1;
            if (snk_valid && snk_ready && snk_data === 8'hC3)
                snk_cnt <= snk_cnt + 32'h1;
        end
    end

    task automatic complete_run();
        $display("counts: %0d compared, %0d mismatched", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got_v, input logic [7:0] exp_v);
        tests_run++;
        if (got_v !== exp_v)
        begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got_v, exp_v);
        end
    endtask

    task automatic chk32(input logic [31:0] got_v, input logic [31:0] exp_v);
        tests_run++;
        if (got_v !== exp_v)
        begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got_v, exp_v);
        end
    endtask

    task automatic wait_high(input bit pick_got, input int bound);
        int n;
        n = 0;
        while ((pick_got ? got : cbw_ready) !== 1'b1 && n < bound)
        begin
            @(posedge clk);
            n++;
        end
        if ((pick_got ? got : cbw_ready) !== 1'b1)
        begin
            errors++;
            $display("unexpected at %0t: wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
            complete_run();
        end
    endtask

    // one whole transaction; SKIP leaves the residue unjudged where it is not defined
    task automatic tx(input bdpe_cmd_type k, input logic hin, input logic [31:0] hl,
        input logic [31:0] dl, input logic [7:0] st, input logic [31:0] res,
        input logic [31:0] nin, input logic [31:0] nz, input logic [31:0] nsnk);
        logic de, le;
        // a direction mismatch is flagged apart from a length mismatch
        de = (hl != 32'h0) && ((k == BDPE_CMD_WRITE && hin) || (k == BDPE_CMD_READ && !hin));
        le = !de && k != BDPE_CMD_UNSUP && (hl != ((k == BDPE_CMD_NONE) ? 32'h0 : dl));
        clr <= 1'b1;
        send_n <= hin ? 32'h0 : hl;
        @(posedge clk);
        clr <= 1'b0;
        cbw_valid <= 1'b1;
        cbw <= '{kind: k, host_in: hin, host_len: hl, dev_len: dl};
        @(posedge clk);
        wait_high(1'b0, 50);
        @(posedge clk);
        cbw_valid <= 1'b0;
        chk8({4'h0, dir_err, len_err, busy, cbw_ready}, {4'h0, de, le, 2'b10});
        wait_high(1'b1, 600);
        chk8(csw_got.status, st);
        if (res !== SKIP)
            chk32(csw_got.residue, res);
        chk32(in_cnt, nin);
        chk32(in_nz, nz);
        chk32(src_cnt, nz);
        chk32(snk_cnt, nsnk);
        wait_high(1'b0, 10);
        $display("test done at %0t: kind %0d len %0h/%0h", $time, k, hl, dl);
    endtask

    task automatic t_no_data();
        tx(BDPE_CMD_NONE, 1'b0, 32'h0, 32'h0, BDPE_ST_PASS, 32'h0, 32'h0, 32'h0, 32'h0);
        tx(BDPE_CMD_READ, 1'b0, 32'h0, 32'h4, BDPE_ST_PHASE, 32'h0, 32'h0, 32'h0, 32'h0);
        tx(BDPE_CMD_WRITE, 1'b0, 32'h0, 32'h4, BDPE_ST_PHASE, 32'h0, 32'h0, 32'h0, 32'h0);
    endtask

    task automatic t_in_cases();
        tx(BDPE_CMD_NONE, 1'b1, 32'h4, 32'h0, BDPE_ST_PASS, 32'h4, 32'h4, 32'h0, 32'h0);
        tx(BDPE_CMD_READ, 1'b1, 32'h6, 32'h2, BDPE_ST_PASS, 32'h4, 32'h6, 32'h2, 32'h0);
        tx(BDPE_CMD_READ, 1'b1, 32'h3, 32'h3, BDPE_ST_PASS, 32'h0, 32'h3, 32'h3, 32'h0);
        tx(BDPE_CMD_READ, 1'b1, 32'h2, 32'h5, BDPE_ST_PHASE, 32'h0, 32'h2, 32'h2, 32'h0);
        tx(BDPE_CMD_WRITE, 1'b1, 32'h3, 32'h3, BDPE_ST_PHASE, SKIP, 32'h3, 32'h0, 32'h0);
    endtask

    task automatic t_out_cases();
        slow <= 1'b1;
        tx(BDPE_CMD_NONE, 1'b0, 32'h3, 32'h0, BDPE_ST_FAIL, 32'h3, 32'h0, 32'h0, 32'h0);
        tx(BDPE_CMD_WRITE, 1'b0, 32'h5, 32'h2, BDPE_ST_FAIL, 32'h3, 32'h0, 32'h0, 32'h2);
        slow <= 1'b0;
        tx(BDPE_CMD_WRITE, 1'b0, 32'h2, 32'h2, BDPE_ST_PASS, 32'h0, 32'h0, 32'h0, 32'h2);
        tx(BDPE_CMD_WRITE, 1'b0, 32'h2, 32'h5, BDPE_ST_PHASE, 32'h0, 32'h0, 32'h0, 32'h2);
        tx(BDPE_CMD_READ, 1'b0, 32'h3, 32'h3, BDPE_ST_PHASE, SKIP, 32'h0, 32'h0, 32'h0);
    endtask

    task automatic t_unsupported();
        tx(BDPE_CMD_UNSUP, 1'b1, 32'h4, 32'h2, BDPE_ST_FAIL, SKIP, 32'h4, 32'h0, 32'h0);
        tx(BDPE_CMD_UNSUP, 1'b0, 32'h2, 32'h2, BDPE_ST_FAIL, SKIP, 32'h0, 32'h0, 32'h0);
    endtask

    // the host stalls until the fifo refuses, then drains it
    task automatic t_fifo_full();
        hold <= 1'b1;
        fork
            tx(BDPE_CMD_READ, 1'b1, 32'h14, 32'h14, BDPE_ST_PASS, 32'h0, 32'h14, 32'h14,
                32'h0);
            begin
                repeat (60) @(posedge clk);
                chk8({7'h0, src_ready}, 8'h00);
                hold <= 1'b0;
            end
        join
    endtask

    initial
    begin
        {arst_n, cbw_valid, src_valid, snk_ready, slow, hold} = '0;
        clr = 1'b1;
        cbw = '0;
        send_n = '0;
        src_data = 8'hA5;
        errors = 0;
        tests_run = 0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        src_valid <= 1'b1;
        t_no_data();
        t_in_cases();
        t_out_cases();
        t_unsupported();
        t_fifo_full();
        complete_run();
    end
endmodule
